// File: dcp_common.sv
// shared constants and types of the wiper position slave, plus its two-flop synchroniser
// assumes one system clock; inputs of the synchroniser come from pins or another clock
package dcp_pkg;
  // device type nibble: value is arbitrary
  localparam logic [3:0]  DEV_TYPE_ID     = 4'ha;
  localparam int          ADDR_TYPE_MSB   = 7;
  localparam int          ADDR_TYPE_LSB   = 4;
  localparam int          ADDR_SEL_MSB    = 3;
  localparam int          ADDR_SEL_LSB    = 1;
  localparam int          ADDR_RW_BIT     = 0;
  localparam int          CMD_OP_MSB      = 7;
  localparam int          CMD_OP_LSB      = 5;
  localparam int          CMD_PTR_MSB     = 3;
  localparam int          CMD_PTR_LSB     = 2;
  localparam logic [2:0]  OP_RD_WIPER     = 3'h4;
  localparam logic [2:0]  OP_WIPER_STORED = 3'h5;  // write wiper (w) / read stored (r)
  localparam logic [2:0]  OP_STORED_XFR   = 3'h6;  // write stored (w) / stored to wiper (r)
  localparam logic [2:0]  OP_XFR_TO_STORE = 3'h7;
  localparam int          POS_W           = 10;
  localparam int          TAPS            = 1024;
  localparam int          NUM_STORED      = 4;
  localparam logic [9:0]  STORED_RST      = 10'h000;
  localparam logic [9:0]  WIPER_RST       = 10'h000;
  localparam int          CLK_HZ          = 40000000;
  localparam int          NV_WRITE_MS     = 10;
  localparam int          NV_WRITE_CYC    = NV_WRITE_MS * (CLK_HZ / 1000);
  localparam int          NV_CNT_W        = 20;
  localparam logic [3:0]  BIT_ACK         = 4'h8;
  localparam logic [3:0]  BIT_LAST        = 4'h7;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RX,
    ST_TX
  } dcp_state_e;
endpackage

`timescale 1ns/10ps
module dcp_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
  } dcp_sync_s;

  dcp_sync_s r;
  dcp_sync_s next_r;

  always_comb begin
    next_r     = r;
    next_r.ff1 = d;
    next_r.ff2 = r.ff1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign q = r.ff2;
endmodule

// File: dcp_master_model.sv
// two-wire bus master model: makes scl, pulls sda low or releases it
// assumes the bench resolves sda from every pull-down with a pull-up
`timescale 1ns/10ps
module dcp_master_model (
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  initial begin
    scl     = 1'b1;  // stands high outside frames
    sda_low = 1'b0;
  end

  // sda set mid low phase, pulse made here
  task automatic bit_io(input logic b, output logic r);
    #40 sda_low = ~b;
    #40 scl = 1'b1;
    #40 r = sda;
    #40 scl = 1'b0;
  endtask

  task automatic start();
    #40 sda_low = 1'b0;
    #40 scl = 1'b1;
    #40 sda_low = 1'b1;
    #40 scl = 1'b0;
  endtask

  task automatic stop();
    #40 sda_low = 1'b1;
    #40 scl = 1'b1;
    #40 sda_low = 1'b0;
    #80;
  endtask

  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  task automatic recv_byte(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(~mack, r);
  endtask
endmodule

// File: dcp_wiper_slave.sv
// two-wire slave front end of a digital potentiometer with wiper and stored positions
// assumes scl/sda from an external master, pull-up on sda, rst is power-up reset
`timescale 1ns/10ps

module dcp_wiper_slave #(
  parameter int NV_CYC = dcp_pkg::NV_WRITE_CYC
) (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       scl,
  input  wire logic                       sda_in,
  output logic                            sda_out,
  output logic                            sda_oe_n,
  input  wire logic [2:0]                 bus_select_pins,
  input  wire logic                       write_protect_n,
  output logic      [dcp_pkg::POS_W-1:0]  wiper_position_bits,
  output logic      [dcp_pkg::TAPS-1:0]   tap_sel,
  output logic                            nv_busy
);
  typedef struct packed {
    logic bitv;
    logic tog;
  } dcp_link_s;

  typedef struct packed {
    dcp_pkg::dcp_state_e                              state;
    logic [3:0]                                       bitcnt;
    logic [1:0]                                       byte_idx;
    logic [7:0]                                       shreg;
    logic                                             rw;
    logic [2:0]                                       opcode;
    logic [1:0]                                       ptr;
    logic                                             ack_now;
    logic                                             tx_next;
    logic [dcp_pkg::POS_W-1:0]                        txword;
    logic [7:0]                                       txreg;
    logic [7:0]                                       dlo;
    logic [dcp_pkg::POS_W-1:0]                        wiper;
    logic [dcp_pkg::NUM_STORED-1:0][dcp_pkg::POS_W-1:0] stored;
    logic                                             nv_pend;
    logic [1:0]                                       nv_ptr;
    logic [dcp_pkg::POS_W-1:0]                        nv_data;
    logic                                             nv_busy;
    logic [dcp_pkg::NV_CNT_W-1:0]                     nv_cnt;
    logic                                             recall;
    logic                                             scl_d;
    logic                                             sda_d;
    logic                                             tog_d;
    logic                                             sda_oe_n;
    logic                                             sda_out;
    logic [dcp_pkg::TAPS-1:0]                         taps;
  } dcp_main_s;

  localparam logic [dcp_pkg::NV_CNT_W-1:0] NV_LOAD = dcp_pkg::NV_CNT_W'(NV_CYC);

  dcp_link_s lr;
  dcp_link_s next_lr;
  dcp_main_s r;
  dcp_main_s next_r;

  logic [6:0] sync_q;
  logic       tog_s;
  logic       scl_s;
  logic       sda_s;
  logic       wp_ok;
  logic [2:0] sel_s;
  logic       ev_start;
  logic       ev_stop;
  logic       ev_fall;
  logic       ev_bit;
  logic [7:0] rx_byte;

  // link domain: sample sda on each rising scl and flag it with a toggle
  always_comb begin
    next_lr      = lr;
    next_lr.bitv = sda_in;
    next_lr.tog  = ~lr.tog;
  end

  always_ff @(posedge scl or posedge rst) begin
    if (rst) begin
      lr <= '0;
    end else begin
      lr <= next_lr;
    end
  end

  dcp_sync #(
    .W (7)
  ) u_sync (
    .clk (clk),
    .rst (rst),
    .d   ({lr.tog, scl, sda_in, write_protect_n, bus_select_pins}),
    .q   (sync_q)
  );

  assign tog_s = sync_q[6];
  assign scl_s = sync_q[5];
  assign sda_s = sync_q[4];
  assign wp_ok = sync_q[3];
  assign sel_s = sync_q[2:0];

  assign ev_start = scl_s && r.scl_d && r.sda_d && !sda_s;
  assign ev_stop  = scl_s && r.scl_d && !r.sda_d && sda_s;
  assign ev_fall  = r.scl_d && !scl_s;
  // bitv is stable for a whole scl period once its toggle is seen
  assign ev_bit   = tog_s != r.tog_d;
  assign rx_byte  = {r.shreg[6:0], lr.bitv};

  always_comb begin
    next_r       = r;
    next_r.scl_d = scl_s;
    next_r.sda_d = sda_s;
    next_r.tog_d = tog_s;
    next_r.taps  = '0;
    next_r.taps[r.wiper] = 1'b1;

    if (r.recall) begin
      next_r.wiper  = r.stored[0];
      next_r.recall = 1'b0;
    end

    if (r.nv_busy) begin
      if (r.nv_cnt == dcp_pkg::NV_CNT_W'(1)) begin
        next_r.stored[r.nv_ptr] = r.nv_data;
        next_r.nv_busy          = 1'b0;
      end else begin
        next_r.nv_cnt = r.nv_cnt - dcp_pkg::NV_CNT_W'(1);
      end
    end

    if (ev_start) begin
      // a repeated start drops whatever byte was in flight
      next_r.state    = dcp_pkg::ST_RX;
      next_r.bitcnt   = '0;
      next_r.byte_idx = '0;
      next_r.ack_now  = 1'b0;
      next_r.tx_next  = 1'b0;
      next_r.nv_pend  = 1'b0;
      next_r.sda_oe_n = 1'b1;
    end else if (ev_stop) begin
      next_r.state    = dcp_pkg::ST_IDLE;
      next_r.ack_now  = 1'b0;
      next_r.sda_oe_n = 1'b1;
      next_r.nv_pend  = 1'b0;
      if (r.nv_pend && wp_ok && !r.nv_busy) begin
        next_r.nv_busy = 1'b1;
        next_r.nv_cnt  = NV_LOAD;
      end
    end else if (ev_bit && r.state != dcp_pkg::ST_IDLE) begin
      if (r.bitcnt != dcp_pkg::BIT_ACK) begin
        next_r.shreg  = rx_byte;
        next_r.bitcnt = r.bitcnt + 4'h1;
        next_r.txreg  = {r.txreg[6:0], 1'b0};
        if (r.state == dcp_pkg::ST_RX && r.bitcnt == dcp_pkg::BIT_LAST) begin
          next_r.state = dcp_pkg::ST_IDLE;
          case (r.byte_idx)
            2'h0: begin
              if (rx_byte[dcp_pkg::ADDR_TYPE_MSB:dcp_pkg::ADDR_TYPE_LSB] == dcp_pkg::DEV_TYPE_ID
                  && rx_byte[dcp_pkg::ADDR_SEL_MSB:dcp_pkg::ADDR_SEL_LSB] == sel_s
                  && !r.nv_busy) begin
                next_r.state   = dcp_pkg::ST_RX;
                next_r.ack_now = 1'b1;
                next_r.rw      = rx_byte[dcp_pkg::ADDR_RW_BIT];
              end
            end
            2'h1: begin
              next_r.opcode  = rx_byte[dcp_pkg::CMD_OP_MSB:dcp_pkg::CMD_OP_LSB];
              next_r.ptr     = rx_byte[dcp_pkg::CMD_PTR_MSB:dcp_pkg::CMD_PTR_LSB];
              next_r.state   = dcp_pkg::ST_RX;
              next_r.ack_now = 1'b1;
              if (r.rw) begin
                case (next_r.opcode)
                  dcp_pkg::OP_RD_WIPER: begin
                    next_r.txword  = r.wiper;
                    next_r.tx_next = 1'b1;
                  end
                  dcp_pkg::OP_WIPER_STORED: begin
                    next_r.txword  = r.stored[next_r.ptr];
                    next_r.tx_next = 1'b1;
                  end
                  dcp_pkg::OP_STORED_XFR: begin
                    next_r.wiper = r.stored[next_r.ptr];
                  end
                  default: begin
                    next_r.state   = dcp_pkg::ST_IDLE;
                    next_r.ack_now = 1'b0;
                  end
                endcase
              end else begin
                case (next_r.opcode)
                  dcp_pkg::OP_WIPER_STORED,
                  dcp_pkg::OP_STORED_XFR: begin
                    next_r.ack_now = 1'b1;
                  end
                  dcp_pkg::OP_XFR_TO_STORE: begin
                    next_r.nv_pend = 1'b1;
                    next_r.nv_ptr  = next_r.ptr;
                    next_r.nv_data = r.wiper;
                  end
                  default: begin
                    next_r.state   = dcp_pkg::ST_IDLE;
                    next_r.ack_now = 1'b0;
                  end
                endcase
              end
            end
            2'h2: begin
              if (!r.rw && r.opcode != dcp_pkg::OP_XFR_TO_STORE) begin
                next_r.dlo     = rx_byte;
                next_r.state   = dcp_pkg::ST_RX;
                next_r.ack_now = 1'b1;
              end
            end
            default: begin
              next_r.state   = dcp_pkg::ST_RX;
              next_r.ack_now = 1'b1;
              if (r.opcode == dcp_pkg::OP_WIPER_STORED) begin
                next_r.wiper = {rx_byte[1:0], r.dlo};
              end else begin
                next_r.nv_pend = 1'b1;
                next_r.nv_ptr  = r.ptr;
                next_r.nv_data = {rx_byte[1:0], r.dlo};
              end
            end
          endcase
        end
      end else begin
        // ninth clock: our acknowledge or the master's
        next_r.bitcnt  = '0;
        next_r.ack_now = 1'b0;
        if (r.state == dcp_pkg::ST_RX) begin
          if (r.tx_next) begin
            next_r.state    = dcp_pkg::ST_TX;
            next_r.txreg    = r.txword[7:0];
            next_r.byte_idx = 2'h2;
            next_r.tx_next  = 1'b0;
          end else if (r.byte_idx == 2'h3) begin
            next_r.state = dcp_pkg::ST_IDLE;
          end else begin
            next_r.byte_idx = r.byte_idx + 2'h1;
          end
        end else if (lr.bitv || r.byte_idx == 2'h3) begin
          next_r.state = dcp_pkg::ST_IDLE;
        end else begin
          next_r.txreg    = {6'h00, r.txword[9:8]};
          next_r.byte_idx = 2'h3;
        end
      end
    end

    if (ev_fall && !ev_start && !ev_stop) begin
      // sda moves only just after scl falls, only ever low or released
      if (next_r.state != dcp_pkg::ST_IDLE && next_r.bitcnt == dcp_pkg::BIT_ACK
          && next_r.ack_now) begin
        next_r.sda_oe_n = 1'b0;
      end else if (next_r.state == dcp_pkg::ST_TX && next_r.bitcnt != dcp_pkg::BIT_ACK) begin
        next_r.sda_oe_n = next_r.txreg[7];
      end else begin
        next_r.sda_oe_n = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r          <= '0;
      r.state    <= dcp_pkg::ST_IDLE;
      r.wiper    <= dcp_pkg::WIPER_RST;
      r.stored   <= {dcp_pkg::NUM_STORED{dcp_pkg::STORED_RST}};
      r.recall   <= 1'b1;
      r.sda_oe_n <= 1'b1;
      r.sda_out  <= 1'b0;
      r.taps     <= dcp_pkg::TAPS'(1);
    end else begin
      r <= next_r;
    end
  end

  assign sda_out             = r.sda_out;
  assign sda_oe_n            = r.sda_oe_n;
  assign wiper_position_bits = r.wiper;
  assign tap_sel             = r.taps;
  assign nv_busy             = r.nv_busy;

  chk_tap_onehot: assert property (@(posedge clk) disable iff (rst) $onehot(tap_sel))
    else $error("tap select not one-hot");
  chk_tap_decode: assert property (@(posedge clk) disable iff (rst)
    $changed(r.wiper) |=> tap_sel[$past(r.wiper)])
    else $error("tap select does not follow wiper");
  chk_sda_low_only: assert property (@(posedge clk) disable iff (rst)
    !sda_oe_n |-> !sda_out)
    else $error("sda driven high");
  chk_drive_on_fall: assert property (@(posedge clk) disable iff (rst)
    $fell(sda_oe_n) |-> $past(ev_fall) && !$past(scl_s))
    else $error("sda pulled low outside an scl falling edge");
  chk_wp_blocks: assert property (@(posedge clk) disable iff (rst)
    $rose(r.nv_busy) |-> $past(wp_ok) && $past(ev_stop))
    else $error("stored write started while protected");
  chk_power_recall: assert property (@(posedge clk) disable iff (rst)
    r.recall |=> r.wiper == $past(r.stored[0]) && !r.recall)
    else $error("power-up recall missing");
  chk_busy_no_ack: assert property (@(posedge clk) disable iff (rst)
    (ev_bit && !ev_start && !ev_stop && r.state == dcp_pkg::ST_RX && r.byte_idx == 2'h0
     && r.bitcnt == dcp_pkg::BIT_LAST && r.nv_busy) |=> !r.ack_now ##1 sda_oe_n)
    else $error("address acknowledged while busy");
  chk_addr_match: assert property (@(posedge clk) disable iff (rst)
    $rose(r.ack_now) && r.byte_idx == 2'h0 |-> r.shreg[3:1] == $past(sel_s))
    else $error("acknowledged a foreign address");
  chk_stop_idle: assert property (@(posedge clk) disable iff (rst)
    ev_stop |=> (r.state == dcp_pkg::ST_IDLE && sda_oe_n) [*2])
    else $error("stop did not return to idle");
  chk_nv_time: assert property (@(posedge clk) disable iff (rst)
    $rose(r.nv_busy) |-> r.nv_cnt == NV_LOAD)
    else $error("stored write time wrong");

  cov_wiper_write: cover property (@(posedge clk) disable iff (rst)
    $changed(r.wiper) && !$past(r.recall));
  cov_read_tx: cover property (@(posedge clk) disable iff (rst)
    $rose(r.state == dcp_pkg::ST_TX));
  cov_nv_write: cover property (@(posedge clk) disable iff (rst) $fell(r.nv_busy));
  cov_busy_poll: cover property (@(posedge clk) disable iff (rst) r.nv_busy && ev_start);
endmodule

// File: two_wire_wiper_position_slave_bench.sv
// self-checking bench of the wiper position slave
// assumes dcp_common.sv, dcp_wiper_slave.sv and the master model are compiled first
`timescale 1ns/10ps
module two_wire_wiper_position_slave_bench;
  localparam int         NV   = 200;
  localparam logic [2:0] PINS = 3'h5;
  localparam logic [7:0] AW   = {dcp_pkg::DEV_TYPE_ID, PINS, 1'b0};
  logic          clk, rst, m_scl, m_low, sda_out, sda_oe_n, write_protect_n, nv_busy;
  logic [2:0]    bus_select_pins;
  logic [9:0]    wiper_position_bits;
  logic [1023:0] tap_sel;
  wire           sda = ~(m_low | ~sda_oe_n);
  int            n_errors = 0;
  int            checked  = 0;

  dcp_wiper_slave #(.NV_CYC(NV)) uut (
    .clk(clk), .rst(rst), .scl(m_scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .bus_select_pins(bus_select_pins),
    .write_protect_n(write_protect_n), .wiper_position_bits(wiper_position_bits),
    .tap_sel(tap_sel), .nv_busy(nv_busy)
  );
  dcp_master_model master (.scl(m_scl), .sda_low(m_low), .sda(sda));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic end_sim();
    if (n_errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // wiper value and its one-hot tap
  task automatic chk_w(input logic [9:0] w);
    chk({6'h00, wiper_position_bits}, {6'h00, w});
    checked++;
    if (tap_sel !== (1024'h1 << w)) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, tap_sel, 1024'h1 << w);
    end
  endtask

  task automatic wr(input logic [7:0] cmd, input logic [9:0] v, input logic data,
                    output logic [3:0] a);
    a = 4'h0;
    master.start();
    master.send_byte(AW, a[3]);
    master.send_byte(cmd, a[2]);
    if (data) begin
      master.send_byte(v[7:0], a[1]);
      master.send_byte({6'h00, v[9:8]}, a[0]);
    end
    master.stop();
  endtask

  // low byte acked by master, high byte nacked
  task automatic rd(input logic [7:0] cmd, input logic data, output logic [15:0] v,
                    output logic [1:0] a);
    v = 16'h0000;
    master.start();
    master.send_byte(AW | 8'h01, a[1]);
    master.send_byte(cmd, a[0]);
    if (data) begin
      master.recv_byte(1'b1, v[7:0]);
      master.recv_byte(1'b0, v[15:8]);
    end
    master.stop();
  endtask

  // ack polling, bounded
  task automatic poll(output int n);
    logic a;
    n = 0;
    do begin
      master.start();
      master.send_byte(AW, a);
      master.stop();
      n++;
    end while (a !== 1'b1 && n < 20);
    if (a !== 1'b1) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, a, 1'b1);
      end_sim();
    end
  endtask

  task automatic t_reset();
    chk({15'h0, sda_oe_n}, 16'h0001);
    chk({15'h0, sda_out}, 16'h0000);
    chk_w(10'h000);
  endtask

  task automatic t_wiper();
    logic [3:0]  a;
    logic [1:0]  b;
    logic [15:0] v;
    wr(8'ha0, 10'h3ff, 1'b1, a);
    chk({12'h0, a}, 16'h000f);
    chk_w(10'h3ff);
    wr(8'ha0, 10'h155, 1'b1, a);
    chk_w(10'h155);
    rd(8'h80, 1'b1, v, b);
    chk({14'h0, b}, 16'h0003);
    chk(v, 16'h0155);
  endtask

  task automatic t_address();
    logic [3:0] a;
    logic       k;
    @(posedge clk) bus_select_pins <= 3'h3;
    repeat (4) @(posedge clk);
    wr(8'ha0, 10'h0aa, 1'b1, a);
    chk({12'h0, a}, 16'h0000);
    chk_w(10'h155);
    @(posedge clk) bus_select_pins <= PINS;
    repeat (4) @(posedge clk);
    master.start();
    master.send_byte({4'h3, PINS, 1'b0}, k);
    master.stop();
    chk({15'h0, k}, 16'h0000);
  endtask

  task automatic t_stored();
    logic [3:0]  a;
    logic [1:0]  b;
    logic [15:0] v;
    int          n;
    wr(8'hc8, 10'h2a3, 1'b1, a);
    chk({12'h0, a}, 16'h000f);
    chk({15'h0, nv_busy}, 16'h0001);
    poll(n);
    chk({15'h0, n > 1}, 16'h0001);
    rd(8'ha8, 1'b1, v, b);
    chk(v, 16'h02a3);
    rd(8'ha0, 1'b1, v, b);
    chk(v, 16'h0000);
    rd(8'hc8, 1'b0, v, b);
    chk({14'h0, b}, 16'h0003);
    chk_w(10'h2a3);
    wr(8'hec, 10'h000, 1'b0, a);
    chk({12'h0, a}, 16'h000c);
    poll(n);
    rd(8'hac, 1'b1, v, b);
    chk(v, 16'h02a3);
    wr(8'h00, 10'h000, 1'b0, a);
    chk({12'h0, a}, 16'h0008);
  endtask

  task automatic t_protect();
    logic [3:0]  a;
    logic [1:0]  b;
    logic [15:0] v;
    int          n;
    @(posedge clk) write_protect_n <= 1'b0;
    repeat (4) @(posedge clk);
    wr(8'hc4, 10'h111, 1'b1, a);
    chk({12'h0, a}, 16'h000f);
    poll(n);
    rd(8'ha4, 1'b1, v, b);
    chk(v, 16'h0000);
    @(posedge clk) write_protect_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask

  task automatic t_abort();
    logic k;
    logic r;
    master.start();
    master.send_byte(AW, k);
    for (int i = 0; i < 3; i++) begin
      master.bit_io(1'b1, r);
    end
    master.stop();
    chk({15'h0, sda_oe_n}, 16'h0001);
    master.start();
    master.send_byte(AW, k);
    master.start();
    master.send_byte(AW, k);
    chk({15'h0, k}, 16'h0001);
    master.send_byte(8'ha0, k);
    master.send_byte(8'h12, k);
    master.send_byte(8'h00, k);
    master.stop();
    chk_w(10'h012);
  endtask

  initial begin
    rst             = 1'b1;
    bus_select_pins = PINS;
    write_protect_n = 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    t_reset();
    t_wiper();
    t_address();
    t_stored();
    t_protect();
    t_abort();
    end_sim();
  end
endmodule
